// >>> hdl/timer_event_channel_select.sv
/*
 * Selection bank that routes event channels to the capture/compare and
 * dead-time inputs of timers 0 to 2, with an AHB-Lite register slave.
 * Assumes a single hclk domain, word-only accesses from one master, async
 * channels from any domain and sync channels already on hclk.
 */
// Functional notes
// (R01) Capture input 0 async pick, bits 3:0
// (R02) Capture input 1 async pick, bits 3:0
// (R03) Capture input 2 async pick, bits 3:0
// (R04) Capture input 0 sync pick, bits 9:8
// (R05) Capture input 1 sync pick, bits 9:8
// (R06) Capture input 2 sync pick, bits 9:8
// (R07) Dead-time and fault inputs: async pick 3:0
// (R08) Software writes unused bits as zero
// (R09) Each pick steers a mux to timer input
// (R10) Unused bits read zero, writes ignored
`timescale 1ns/100ps
`include "event_route_cfg.svh"

module timer_event_channel_select
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [`ASYNC_CHANNELS-1:0] async_channel_in,
    input wire logic [`SYNC_CHANNELS-1:0] sync_channel_in,
    output logic [`CAPTURE_INPUTS-1:0] capture_async_event,
    output logic [`CAPTURE_INPUTS-1:0] capture_sync_event,
    output logic [`DEADTIME_INPUTS-1:0] deadtime_event
);

    event_route_pkg::select_state_t s_q;
    event_route_pkg::select_state_t s_d;
    logic [`ASYNC_CHANNELS-1:0] async_safe;
    logic [`CAPTURE_INPUTS-1:0] cap_async_w;
    logic [`CAPTURE_INPUTS-1:0] cap_sync_w;
    logic [`DEADTIME_INPUTS-1:0] dt_async_w;
    logic take;
    event_route_pkg::reg_hit_t addr_hit;

    // Map a byte offset to a slot; capture slots first, dead-time after
    function automatic event_route_pkg::reg_hit_t decode_offset(
        input logic [`ADDR_BITS-1:0] off);
        event_route_pkg::reg_hit_t r;
        r.hit = 1'b1;
        r.idx = 5'h00;
        case (off)
            `T0_CAP1_OFFSET: r.idx = 5'h00;
            `T0_CAP2_OFFSET: r.idx = 5'h01;
            `T1_CAP0_OFFSET: r.idx = 5'h02;
            `T1_CAP1_OFFSET: r.idx = 5'h03;
            `T1_CAP2_OFFSET: r.idx = 5'h04;
            `T2_CAP0_OFFSET: r.idx = 5'h05;
            `T2_CAP1_OFFSET: r.idx = 5'h06;
            `T2_CAP2_OFFSET: r.idx = 5'h07;
            `T0_DEAD_OFFSET: r.idx = 5'h08;
            `T0_FAULT1_OFFSET: r.idx = 5'h09;
            `T0_FAULT2_OFFSET: r.idx = 5'h0A;
            `T1_DEAD_OFFSET: r.idx = 5'h0B;
            `T1_FAULT1_OFFSET: r.idx = 5'h0C;
            `T1_FAULT2_OFFSET: r.idx = 5'h0D;
            `T2_DEAD_OFFSET: r.idx = 5'h0E;
            `T2_FAULT1_OFFSET: r.idx = 5'h0F;
            `T2_FAULT2_OFFSET: r.idx = 5'h10;
            default:
            begin
                r.hit = 1'b0;
                r.idx = 5'h00;
            end
        endcase
        return r;
    endfunction

    // Slots below the dead-time group carry a sync pick as well
    function automatic logic is_capture(input event_route_pkg::reg_index_t idx);
        return idx < 5'(`CAPTURE_INPUTS);
    endfunction

    // Keep only implemented fields of a written word
    function automatic event_route_pkg::route_sel_t write_fields(
        input logic [31:0] data,
        input event_route_pkg::reg_index_t idx);
        event_route_pkg::route_sel_t v;
        v.async_pick = data[`ASYNC_MSB:`ASYNC_LSB]; // R01 R02 R03 R07
        v.sync_pick = is_capture(idx) ? data[`SYNC_MSB:`SYNC_LSB] : 2'h0; // R04 R05 R06
        return v; // R08 R10
    endfunction

    // Place fields back in their bit positions; all other bits read zero
    function automatic logic [31:0] read_fields(input event_route_pkg::route_sel_t v);
        logic [31:0] w;
        w = 32'h0000_0000; // R10
        w[`ASYNC_MSB:`ASYNC_LSB] = v.async_pick;
        w[`SYNC_MSB:`SYNC_LSB] = v.sync_pick;
        return w;
    endfunction

    // Async channels are retimed before any mux looks at them
    channel_sync u_channel_sync
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .chan_raw(async_channel_in),
        .chan_safe(async_safe)
    );

    // Two muxes per capture input, async and sync paths kept apart
    genvar gi;
    generate
        for (gi = 0; gi < `CAPTURE_INPUTS; gi++)
        begin : g_capture
            assign cap_async_w[gi] = async_safe[s_q.sel[gi].async_pick]; // R09
            assign cap_sync_w[gi] = sync_channel_in[s_q.sel[gi].sync_pick]; // R09
        end
        for (gi = 0; gi < `DEADTIME_INPUTS; gi++)
        begin : g_deadtime
            assign dt_async_w[gi] =
                async_safe[s_q.sel[gi + `CAPTURE_INPUTS].async_pick]; // R09
        end
    endgenerate

    // Address phase qualifier; hsize is not checked, only words are used
    assign take = hsel && hready && htrans[1];
    assign addr_hit = decode_offset(haddr[`ADDR_BITS-1:0]);

    // Next state: data-phase write, address-phase read, routed outputs
    always_comb
    begin
        s_d = s_q;
        s_d.ready = 1'b1; // Never inserts wait states
        s_d.resp = 1'b0; // Always OKAY, unmapped accesses included
        // Commit the write whose address was taken in the previous cycle
        if (s_q.wr_pend && s_q.wr_hit)
        begin
            s_d.sel[s_q.wr_idx] = write_fields(hwdata, s_q.wr_idx); // R01 R04 R07
        end
        s_d.wr_pend = take && hwrite;
        s_d.wr_hit = addr_hit.hit;
        s_d.wr_idx = addr_hit.idx;
        // Read data is registered here so hrdata leaves a flip-flop;
        // a write still in its data phase is forwarded so no stale value
        // is seen on a read that follows it back to back
        if (take && !hwrite)
        begin
            if (!addr_hit.hit)
            begin
                s_d.rdata = `RDATA_RESET; // Unmapped reads zero
            end
            else if (s_q.wr_pend && s_q.wr_hit && s_q.wr_idx == addr_hit.idx)
            begin
                s_d.rdata = read_fields(write_fields(hwdata, addr_hit.idx)); // R10
            end
            else
            begin
                s_d.rdata = read_fields(s_q.sel[addr_hit.idx]); // R10
            end
        end
        // Timer inputs follow the current picks one cycle later
        s_d.cap_async = cap_async_w; // R09
        s_d.cap_sync = cap_sync_w; // R09
        s_d.dt_async = dt_async_w; // R09
    end

    // State register; every pick clears to zero on reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_q <= '0; // R01 R02 R03 R04 R05 R06 R07
            s_q.ready <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign hrdata = s_q.rdata;
    assign hreadyout = s_q.ready;
    assign hresp = s_q.resp;
    assign capture_async_event = s_q.cap_async;
    assign capture_sync_event = s_q.cap_sync;
    assign deadtime_event = s_q.dt_async;

endmodule // timer_event_channel_select

// >>> hdl/event_route_cfg.svh
/*
 * Constants of the timer event channel selection bank: register byte
 * offsets, field positions, widths and reset values.
 * Assumes it is included by bare name, once or more, by package and modules.
 */
`ifndef EVENT_ROUTE_CFG_SVH
`define EVENT_ROUTE_CFG_SVH

// Byte offsets of the capture/compare selection registers
`define T0_CAP1_OFFSET 12'h158
`define T0_CAP2_OFFSET 12'h15C
`define T1_CAP0_OFFSET 12'h16C
`define T1_CAP1_OFFSET 12'h170
`define T1_CAP2_OFFSET 12'h174
`define T2_CAP0_OFFSET 12'h184
`define T2_CAP1_OFFSET 12'h188
`define T2_CAP2_OFFSET 12'h18C

// Byte offsets of the dead-time selection registers
`define T0_DEAD_OFFSET 12'h160
`define T0_FAULT1_OFFSET 12'h164
`define T0_FAULT2_OFFSET 12'h168
`define T1_DEAD_OFFSET 12'h178
`define T1_FAULT1_OFFSET 12'h17C
`define T1_FAULT2_OFFSET 12'h180
`define T2_DEAD_OFFSET 12'h190
`define T2_FAULT1_OFFSET 12'h194
`define T2_FAULT2_OFFSET 12'h198

// Field positions inside a selection register
`define ASYNC_LSB 0
`define ASYNC_MSB 3
`define SYNC_LSB 8
`define SYNC_MSB 9

// Sizes of the bank and of the channel sets
`define ADDR_BITS 12
`define ASYNC_CHANNELS 16
`define SYNC_CHANNELS 4
`define CAPTURE_INPUTS 8
`define DEADTIME_INPUTS 9
`define ROUTE_REGS 17
`define INDEX_BITS 5

// Reset values
`define ROUTE_RESET 6'h00
`define RDATA_RESET 32'h0000_0000

`endif

// >>> hdl/event_route_pkg.sv
/*
 * Types shared by the selection bank and its channel synchroniser.
 * Assumes the constants header is on the include path.
 */
`include "event_route_cfg.svh"

package event_route_pkg;

    typedef logic [`ASYNC_MSB-`ASYNC_LSB:0] async_sel_t;
    typedef logic [`SYNC_MSB-`SYNC_LSB:0] sync_sel_t;
    typedef logic [`INDEX_BITS-1:0] reg_index_t;

    // One selection: synchronous pick above asynchronous pick
    typedef struct packed {
        sync_sel_t sync_pick;
        async_sel_t async_pick;
    } route_sel_t;

    // Result of an address decode
    typedef struct packed {
        logic hit;
        reg_index_t idx;
    } reg_hit_t;

    // State of the two-stage channel synchroniser
    typedef struct packed {
        logic [`ASYNC_CHANNELS-1:0] stage1;
        logic [`ASYNC_CHANNELS-1:0] stage2;
    } sync_state_t;

    // Whole state of the selection bank
    typedef struct packed {
        logic wr_pend;
        logic wr_hit;
        reg_index_t wr_idx;
        logic [31:0] rdata;
        logic ready;
        logic resp;
        route_sel_t [`ROUTE_REGS-1:0] sel;
        logic [`CAPTURE_INPUTS-1:0] cap_async;
        logic [`CAPTURE_INPUTS-1:0] cap_sync;
        logic [`DEADTIME_INPUTS-1:0] dt_async;
    } select_state_t;

endpackage

// >>> hdl/channel_sync.sv
/*
 * Two flip-flop synchroniser for the asynchronous event channels.
 * Assumes the channels change with no relation to hclk; only the second
 * stage may be read by other logic.
 */
`timescale 1ns/100ps
`include "event_route_cfg.svh"

module channel_sync
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [`ASYNC_CHANNELS-1:0] chan_raw,
    output logic [`ASYNC_CHANNELS-1:0] chan_safe
);

    event_route_pkg::sync_state_t s_q;
    event_route_pkg::sync_state_t s_d;

    // First stage feeds only the second
    always_comb
    begin
        s_d = s_q;
        s_d.stage1 = chan_raw;
        s_d.stage2 = s_q.stage1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign chan_safe = s_q.stage2;

endmodule // channel_sync

// >>> verif/event_route_props.sv
/* Port checker of the selection bank: reserved read bits and channel routing.
   Assumes one hclk domain, hready tied to hreadyout, reset while hresetn low. */
`timescale 1ns/100ps
module event_route_props
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [31:0] hrdata,
    input wire logic [15:0] async_channel_in,
    input wire logic [3:0] sync_channel_in,
    input wire logic [7:0] capture_async_event,
    input wire logic [7:0] capture_sync_event,
    input wire logic [8:0] deadtime_event
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Reserved read bits stay clear whatever software wrote
    property p_rsv_hi; hrdata[31:10] == 22'h0; endproperty
    a_rsv_hi: assert property (p_rsv_hi) else $error("upper bits set");
    property p_rsv_mid; hrdata[7:4] == 4'h0; endproperty
    a_rsv_mid: assert property (p_rsv_mid) else $error("middle bits set");
    // Uniform channels give one answer for every pick; sync 1 cycle, async 3
    property p_sync_lo; (sync_channel_in == '0) [*2] |-> capture_sync_event == '0; endproperty
    a_sync_lo: assert property (p_sync_lo) else $error("sync route high");
    property p_sync_hi; (sync_channel_in == '1) [*2] |-> capture_sync_event == '1; endproperty
    a_sync_hi: assert property (p_sync_hi) else $error("sync route low");
    property p_cap_lo; (async_channel_in == '0) [*4] |-> capture_async_event == '0; endproperty
    a_cap_lo: assert property (p_cap_lo) else $error("async route high");
    property p_cap_hi; (async_channel_in == '1) [*4] |-> capture_async_event == '1; endproperty
    a_cap_hi: assert property (p_cap_hi) else $error("async route low");
    property p_dt_lo; (async_channel_in == '0) [*4] |-> deadtime_event == '0; endproperty
    a_dt_lo: assert property (p_dt_lo) else $error("dead-time route high");
    property p_dt_hi; (async_channel_in == '1) [*4] |-> deadtime_event == '1; endproperty
    a_dt_hi: assert property (p_dt_hi) else $error("dead-time route low");
    c_sync: cover property (capture_sync_event != '0);
    c_dt: cover property (deadtime_event != '0);
    c_read: cover property (hrdata[9:8] != 2'h0);
endmodule // event_route_props

// >>> verif/event_source_model.sv
/* Model of the event routing network feeding the bank's channel inputs.
   Assumes the bench sets the wanted levels just after a rising edge. */
`timescale 1ns/100ps
module event_source_model
(
    input wire logic hclk,
    input wire logic [15:0] async_want,
    input wire logic [3:0] sync_want,
    output logic [15:0] async_channel_in,
    output logic [3:0] sync_channel_in
);
    // Sync channels launch from hclk like any on-clock producer
    always @(posedge hclk) sync_channel_in <= sync_want;
    // Async channels move off-phase so the synchroniser sees real skew
    always @(posedge hclk) async_channel_in <= #1.3 async_want;
endmodule // event_source_model

// >>> verif/timer_event_channel_select_tb.sv
/* Bench of the selection bank: AHB-Lite master tasks and routing scenarios.
   Assumes the source model and the checker are compiled before this file. */
`timescale 1ns/100ps
module timer_event_channel_select_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [15:0] async_want = 16'h0000;
    logic [3:0] sync_want = 4'h0;
    logic [15:0] async_ch;
    logic [3:0] sync_ch;
    logic [7:0] cap_a;
    logic [7:0] cap_s;
    logic [8:0] dt_ev;
    int err_count = 0;
    int cmp_count = 0;
    // Which of the 17 words from 0x158 are capture registers
    localparam logic [16:0] CAP_MAP = 17'h038E3;
    always #2 hclk = ~hclk;
    event_source_model src (.hclk(hclk), .async_want(async_want), .sync_want(sync_want),
        .async_channel_in(async_ch), .sync_channel_in(sync_ch));
    timer_event_channel_select dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .async_channel_in(async_ch), .sync_channel_in(sync_ch),
        .capture_async_event(cap_a), .capture_sync_event(cap_s), .deadtime_event(dt_ev));
    task automatic results;
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
            err_count++;
        end
    endtask
    // Single word transfer; both phases wait for ready, read data taken at the end
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask
    // Every word comes out of reset cleared
    task automatic s_reset_values;
        logic [31:0] rd;
        for (int i = 0; i < 17; i++)
        begin
            xfer(1'b0, 32'h0000_0158 + 4 * i, 32'h0, rd);
            chk(rd, 32'h0);
        end
    endtask
    // All-ones writes, read straight back; the unmapped word stays empty
    task automatic s_unused_bits;
        logic [31:0] rd;
        for (int i = 0; i < 17; i++)
        begin
            xfer(1'b1, 32'h0000_0158 + 4 * i, 32'hFFFF_FFFF, rd);
            xfer(1'b0, 32'h0000_0158 + 4 * i, 32'h0, rd);
            chk(rd, CAP_MAP[i] ? 32'h0000_030F : 32'h0000_000F);
        end
        xfer(1'b1, 32'h0000_0154, 32'hFFFF_FFFF, rd);
        xfer(1'b0, 32'h0000_0154, 32'h0, rd);
        chk(rd, 32'h0);
    endtask
    // Each pick steers its own output bit: one-hot, then the inverse pattern
    task automatic s_routes;
        logic [31:0] rd;
        logic [3:0] ch;
        int c = 0;
        int d = 0;
        for (int i = 0; i < 17; i++)
        begin
            ch = 4'(i + 5);
            // Dead-time words keep their reserved bits 9:8 at zero
            xfer(1'b1, 32'h0000_0158 + 4 * i,
                {22'h0, CAP_MAP[i] ? ch[1:0] : 2'h0, 4'h0, ch}, rd);
            for (int k = 0; k < 2; k++)
            begin
                async_want <= k ? ~(16'h0001 << ch) : (16'h0001 << ch);
                sync_want <= k ? ~(4'h1 << ch[1:0]) : (4'h1 << ch[1:0]);
                repeat (6) @(posedge hclk);
                if (CAP_MAP[i])
                    chk({30'h0, cap_a[c], cap_s[c]}, k ? 32'h0 : 32'h3);
                else
                    chk({31'h0, dt_ev[d]}, k ? 32'h0 : 32'h1);
            end
            c += CAP_MAP[i];
            d += !CAP_MAP[i];
        end
    endtask
    // Uniform channels: every pick must give one level on every output bit
    task automatic s_uniform;
        for (int k = 0; k < 2; k++)
        begin
            async_want <= k ? 16'h0000 : 16'hFFFF;
            sync_want <= k ? 4'h0 : 4'hF;
            repeat (6) @(posedge hclk);
            chk({24'h0, cap_a}, k ? 32'h0 : 32'h0000_00FF);
            chk({24'h0, cap_s}, k ? 32'h0 : 32'h0000_00FF);
            chk({23'h0, dt_ev}, k ? 32'h0 : 32'h0000_01FF);
        end
    endtask
    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        s_reset_values();
        s_unused_bits();
        s_routes();
        s_uniform();
        // Reset in mid-run: picks written above must clear again
        hresetn <= 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        s_reset_values();
        results();
    end
    // The run needs under 1000 cycles; this cuts a hang short
    initial
    begin
        repeat (20000) @(posedge hclk);
        err_count++;
        results();
    end
endmodule // timer_event_channel_select_tb
bind timer_event_channel_select event_route_props props (.hclk(hclk), .hresetn(hresetn),
    .hrdata(hrdata), .async_channel_in(async_channel_in), .sync_channel_in(sync_channel_in),
    .capture_async_event(capture_async_event), .capture_sync_event(capture_sync_event),
    .deadtime_event(deadtime_event));
